/* verilog/pwm_mod_cfg.svh */
// offsets, field positions, reset values and timing counts of the modulator
`ifndef PWM_MOD_CFG_SVH
`define PWM_MOD_CFG_SVH

// -------------------------------------------------------------------------
// timing
// -------------------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define MIN_OFF_NS      50
`define MIN_OFF_CYC     ((`MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SSM_LSB_NS      25
`define FIXED_TON_BASE  16'h0003
`define FLL_FRAC        7
`define BAL_SHIFT       6

// -------------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_TON         8'h04
`define OFF_PERIOD      8'h08
`define OFF_BAL         8'h0c
`define OFF_SPREAD      8'h10
`define OFF_STATUS      8'h14
`define OFF_SHED_BASE   8'h20
`define OFF_SHED_LAST   8'h38

// -------------------------------------------------------------------------
// fields
// -------------------------------------------------------------------------
`define CTRL_FF_EN      0
`define CTRL_SS_EN      1
`define CTRL_BOOST_DIS  2
`define CTRL_LIMIT      5:4
`define CTRL_MERGE      7:6
`define CTRL_SHED_DLY   9:8
`define CTRL_MIN_PH     14:12
`define CTRL_ASSIGNED   19:16
`define TON_CONST       9:0
`define TON_GAIN        25:16
`define PERIOD_FIELD    15:0
`define BAL_FIELD       7:0
`define SS_AMPL         15:0
`define SS_STEP         30:16
`define SHED_ADD        7:0
`define SHED_DROP       15:8

// -------------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------------
`define RST_CTRL        32'h0008_0000
`define RST_TON         32'h0002_0000
`define RST_PERIOD      32'h0000_0064
`define RST_BAL         32'h0000_0080
`define RST_SPREAD      32'h0000_0000
`define RST_ACTIVE      4'h8
`define RST_SHED2       16'h0b0f
`define RST_SHED3       16'h161b
`define RST_SHED4       16'h1f23
`define RST_SHED5       16'h2d31
`define RST_SHED6       16'h3c40
`define RST_SHED7       16'h484d
`define RST_SHED8       16'h565a

`endif

/* verilog/pwm_mod_pkg.sv */
// types shared by the modulator
package pwm_mod_pkg;
	typedef enum logic [1:0] {
		MERGE_EXTEND   = 2'b00,
		MERGE_RESTART  = 2'b01,
		MERGE_SKIP_ON  = 2'b10,
		MERGE_SKIP_ALL = 2'b11
	} merge_policy_t;
	typedef enum logic [1:0] {
		LIM_FULL    = 2'b00,
		LIM_ZERO    = 2'b01,
		LIM_QUARTER = 2'b10,
		LIM_NONE    = 2'b11
	} corr_limit_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ON   = 2'b01,
		PH_OFF  = 2'b10
	} phase_state_t;
endpackage : pwm_mod_pkg

/* verilog/pwm_modulator.sv */
// multiphase pwm modulator core with apb configuration registers
// How it works
// RULE1 - one enable bit picks feedforward on time; cleared at reset
// RULE2 - feedforward on time is vout over vin times the pwm period
// RULE3 - otherwise on time is the 10-bit constant; zero gives three clocks
// RULE4 - frequency loop trims on time by period error against target/N
// RULE5 - 10-bit loop gain, default 2; zero switches the loop off
// RULE6 - 2-bit limit: full, zero, quarter or unbounded correction
// RULE7 - spread enable bit, off at reset, ramps on time through the loop
// RULE8 - 16-bit amplitude and 15-bit step, lsb 25 ns/128, both reset zero
// RULE9 - software keeps the frequency loop on whenever spread is on
// RULE10 - per phase trim from average minus phase current times gain/64
// RULE11 - policy 0 stretches on time by nominal per extra pulse
// RULE12 - policy 1 restarts the on time at each pulse during on
// RULE13 - policies 0-2 delay a pulse in the off window until it ends
// RULE14 - policies 2,3 drop pulses during on; 3 also in off window
// RULE15 - sum above add threshold past one conversion enables next phase
// RULE16 - sum below drop threshold past conversion plus delay drops one
// RULE17 - add and drop thresholds for phases 2 to 8 are 8-bit fields
// RULE18 - an add threshold of zero freezes the assigned phase count
// RULE19 - drop delay code picks 8, 16, 24 or 32 pwm periods
// RULE20 - minimum phase field keeps that many phases; 0 and 1 mean one
// RULE21 - minimum phase setting wins over the assigned count
// RULE22 - short oscillator period adds one phase at once
// RULE23 - boost disable bit, clear at reset, stops the fast add
`timescale 1ns/1ns
`default_nettype none
`include "pwm_mod_cfg.svh"
module pwm_modulator import pwm_mod_pkg::*; (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// loop measurements
	input  wire logic        OSC_PULSE,
	input  wire logic [15:0] OSC_PERIOD,
	input  wire logic [11:0] VIN_CODE,
	input  wire logic [11:0] VOUT_CODE,
	input  wire logic [63:0] PHASE_CURRENT,
	input  wire logic [7:0]  AVG_CURRENT,
	input  wire logic [15:0] SUM_CURRENT,
	input  wire logic        CUR_VALID,
	// power stage side
	output logic      [7:0]  PWM_OUT,
	output logic      [7:0]  PWM_OE,
	output logic      [7:0]  MON_EN,
	output logic      [3:0]  ACTIVE_PHASES
);
	localparam logic [15:0] SHED_RST [2:8] = '{`RST_SHED2, `RST_SHED3,
		`RST_SHED4, `RST_SHED5, `RST_SHED6, `RST_SHED7, `RST_SHED8};

	logic [31:0] ctrl, ton_cfg, period_cfg, bal_cfg, spread_cfg;
	logic [15:0] shed_cfg [2:8];
	logic [3:0]  n_act, next_n_act;
	logic [2:0]  ptr;
	logic signed [29:0] corr;
	logic signed [17:0] ss_pos;
	logic        ss_down, add_seen, drop_seen;
	logic [15:0] per_cnt, ton_nom;
	logic [5:0]  drop_per;
	logic [7:0]  active, hit;
	logic [15:0] ton_ph [8];

	function automatic logic [7:0] shed_thr(input logic [3:0] ph,
			input logic drop);
		shed_thr = 8'h00;
		if (ph >= 4'd2 && ph <= 4'd8)
			shed_thr = drop ? shed_cfg[ph][`SHED_DROP]
				: shed_cfg[ph][`SHED_ADD];
	endfunction : shed_thr

	function automatic logic signed [29:0] limit_corr(
			input logic signed [29:0] v, input corr_limit_t sel,
			input logic signed [29:0] full);
		logic signed [29:0] lim;
		lim = (sel == LIM_QUARTER) ? (full >>> 2) : full;
		if (sel == LIM_ZERO)
			limit_corr = '0;
		else if (sel == LIM_NONE)
			limit_corr = v;
		else if (v > lim)
			limit_corr = lim;
		else if (v < -lim)
			limit_corr = -lim;
		else
			limit_corr = v;
	endfunction : limit_corr

	// ---------------------------------------------------------------------
	// apb register file
	// ---------------------------------------------------------------------
	wire         wr       = PSEL && PENABLE && PWRITE;
	wire         shed_hit = PADDR >= `OFF_SHED_BASE &&
		PADDR <= `OFF_SHED_LAST && PADDR[1:0] == 2'b00;
	wire [3:0]   shed_idx = {1'b0, PADDR[4:2]} + 4'd2;
	wire         addr_ok  = shed_hit || PADDR == `OFF_CTRL ||
		PADDR == `OFF_TON || PADDR == `OFF_PERIOD || PADDR == `OFF_BAL ||
		PADDR == `OFF_SPREAD || PADDR == `OFF_STATUS;
	logic [31:0] rd_mux;

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (shed_hit)
			rd_mux = {16'h0000, shed_cfg[shed_idx]};
		else if (PADDR == `OFF_CTRL)
			rd_mux = ctrl;
		else if (PADDR == `OFF_TON)
			rd_mux = ton_cfg;
		else if (PADDR == `OFF_PERIOD)
			rd_mux = period_cfg;
		else if (PADDR == `OFF_BAL)
			rd_mux = bal_cfg;
		else if (PADDR == `OFF_SPREAD)
			rd_mux = spread_cfg;
		else if (PADDR == `OFF_STATUS)
			rd_mux = {ton_nom, 12'h000, n_act};
	end

	// read data captured in the setup cycle, so zero wait states
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
			PRDATA <= rd_mux;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			ctrl       <= `RST_CTRL;
			ton_cfg    <= `RST_TON;
			period_cfg <= `RST_PERIOD;
			bal_cfg    <= `RST_BAL;
			spread_cfg <= `RST_SPREAD;
		end else if (wr) begin
			if (PADDR == `OFF_CTRL)
				ctrl <= PWDATA;
			if (PADDR == `OFF_TON)
				ton_cfg <= PWDATA;
			if (PADDR == `OFF_PERIOD)
				period_cfg <= PWDATA;
			if (PADDR == `OFF_BAL)
				bal_cfg <= PWDATA;
			if (PADDR == `OFF_SPREAD)
				spread_cfg <= PWDATA;
		end
	end

	for (genvar i = 2; i <= 8; i++) begin : g_shed
		always_ff @(posedge CLK_SYS) begin
			if (!NRST)
				shed_cfg[i] <= SHED_RST[i];
			else if (wr && shed_hit && shed_idx == 4'(i))
				shed_cfg[i] <= PWDATA[15:0]; // RULE17
		end
	end

	wire              ff_en     = ctrl[`CTRL_FF_EN];
	wire              ss_en     = ctrl[`CTRL_SS_EN];
	wire              boost_dis = ctrl[`CTRL_BOOST_DIS];
	wire corr_limit_t lim_sel   = corr_limit_t'(ctrl[`CTRL_LIMIT]);
	wire merge_policy_t pol     = merge_policy_t'(ctrl[`CTRL_MERGE]);
	wire [1:0]        dly_sel   = ctrl[`CTRL_SHED_DLY];
	wire [2:0]        min_ph    = ctrl[`CTRL_MIN_PH];
	wire [3:0]        assigned  = ctrl[`CTRL_ASSIGNED];
	wire [9:0]        ton_const = ton_cfg[`TON_CONST];
	wire [9:0]        fll_gain  = ton_cfg[`TON_GAIN];
	wire [15:0]       period    = period_cfg[`PERIOD_FIELD];
	wire [7:0]        bal_gain  = bal_cfg[`BAL_FIELD];
	wire [15:0]       ss_ampl   = spread_cfg[`SS_AMPL];
	wire [14:0]       ss_step   = spread_cfg[`SS_STEP];

	// ---------------------------------------------------------------------
	// nominal on time and frequency loop
	// ---------------------------------------------------------------------
	wire [27:0] ff_prod = VOUT_CODE * period;
	wire [27:0] ff_quot = (VIN_CODE == 12'h000) ? 28'hfff_ffff
		: ff_prod / {16'h0000, VIN_CODE}; // RULE2
	wire [15:0] ton_ff  = (|ff_quot[27:16]) ? 16'hffff : ff_quot[15:0];
	assign ton_nom = ff_en ? ton_ff // RULE1
		: `FIXED_TON_BASE + {6'h00, ton_const}; // RULE3

	wire [15:0] per_target = period / {12'h000, n_act};
	wire signed [17:0] fll_err = $signed({2'b00, OSC_PERIOD})
		- $signed({2'b00, per_target});
	wire signed [29:0] fll_delta = $signed({1'b0, fll_gain}) * fll_err;
	wire signed [29:0] corr_full = $signed({7'h00, ton_nom, 7'h00});
	wire signed [31:0] ss_eff = ss_pos * `SSM_LSB_NS / `CLK_PERIOD_NS;
	wire signed [29:0] corr_tot = limit_corr(corr + ss_eff[29:0],
		lim_sel, corr_full); // RULE6
	wire signed [23:0] ton_adj = $signed({8'h00, ton_nom})
		+ 24'(corr_tot >>> `FLL_FRAC);

	// longer period than target means too much on time, so pull it down
	always_ff @(posedge CLK_SYS) begin
		if (!NRST || fll_gain == 10'h000)
			corr <= '0; // RULE5
		else if (OSC_PULSE)
			corr <= limit_corr(corr - fll_delta, lim_sel, corr_full); // RULE4
	end

	// triangle ramp; held at zero unless the frequency loop runs
	wire signed [17:0] ss_amp = $signed({2'b00, ss_ampl});
	wire signed [17:0] ss_nxt = ss_down ? ss_pos - $signed({3'b000, ss_step})
		: ss_pos + $signed({3'b000, ss_step});
	always_ff @(posedge CLK_SYS) begin
		if (!NRST || !ss_en || fll_gain == 10'h000) begin // RULE7 RULE9
			ss_pos  <= '0;
			ss_down <= 1'b0;
		end else if (OSC_PULSE) begin
			ss_pos  <= ss_nxt; // RULE8
			ss_down <= ss_down ? (ss_nxt > -ss_amp) : (ss_nxt >= ss_amp);
		end
	end

	// ---------------------------------------------------------------------
	// interleaver and per phase on time generators
	// ---------------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			ptr <= 3'h0;
		else if (OSC_PULSE)
			ptr <= ({1'b0, ptr} + 4'd1 >= n_act) ? 3'h0 : ptr + 3'h1;
	end

	for (genvar k = 0; k < 8; k++) begin : g_ph
		phase_state_t st;
		logic [15:0]  cnt;
		logic         pend;
		wire signed [8:0]  bdiff = $signed({1'b0, AVG_CURRENT})
			- $signed({1'b0, PHASE_CURRENT[8*k +: 8]});
		wire signed [17:0] bprod = bdiff * $signed({1'b0, bal_gain});
		wire signed [24:0] tk = 25'(ton_adj)
			+ 25'(bprod >>> `BAL_SHIFT); // RULE10
		wire [16:0] ext = {1'b0, cnt} + {1'b0, ton_ph[k]} - 17'h00001;
		wire        take = hit[k] && pol != MERGE_SKIP_ALL;

		assign ton_ph[k] = (tk < 25'sd1) ? 16'h0001
			: (tk > 25'sh0_ffff) ? 16'hffff : tk[15:0];
		assign active[k] = 4'(k) < n_act;
		assign hit[k]    = OSC_PULSE && ptr == 3'(k) && active[k];
		assign PWM_OUT[k] = st == PH_ON;

		always_ff @(posedge CLK_SYS) begin
			if (!NRST || !active[k]) begin
				st   <= PH_IDLE;
				cnt  <= 16'h0000;
				pend <= 1'b0;
			end else begin
				unique case (st)
					PH_IDLE: if (hit[k]) begin
						st  <= PH_ON;
						cnt <= ton_ph[k];
					end
					PH_ON: if (hit[k] && pol == MERGE_EXTEND) begin
						cnt <= ext[16] ? 16'hffff : ext[15:0]; // RULE11
					end else if (hit[k] && pol == MERGE_RESTART) begin
						cnt <= ton_ph[k]; // RULE12
					end else if (cnt <= 16'h0001) begin
						st  <= PH_OFF; // RULE14
						cnt <= 16'(`MIN_OFF_CYC);
					end else begin
						cnt <= cnt - 16'h0001;
					end
					PH_OFF: if (cnt <= 16'h0001) begin
						st   <= (pend || take) ? PH_ON : PH_IDLE; // RULE13
						cnt  <= ton_ph[k];
						pend <= 1'b0;
					end else begin
						cnt  <= cnt - 16'h0001;
						pend <= pend || take; // RULE14
					end
					default: st <= PH_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------------
	// dynamic shedding and fast boost
	// ---------------------------------------------------------------------
	wire [3:0] floor_n  = (min_ph == 3'h0) ? 4'h1 : {1'b0, min_ph}; // RULE20
	wire [3:0] top_n    = (floor_n > assigned) ? floor_n : assigned; // RULE21
	// the lookup reads the threshold table, so rerun it on every write
	logic [7:0] add_thr, drop_thr;
	always_comb begin
		add_thr  = shed_thr(n_act + 4'd1, 1'b0);
		drop_thr = shed_thr(n_act, 1'b1);
	end
	wire       add_ok   = SUM_CURRENT >= {8'h00, add_thr};
	wire       drop_ok  = SUM_CURRENT <= {8'h00, drop_thr};
	wire [5:0] drop_dly = {1'b0, dly_sel, 3'b000} + 6'd8; // RULE19
	wire       per_tick = per_cnt + 16'h0001 >= period;
	wire [19:0] boost_prod = OSC_PERIOD * (n_act + 4'd1);
	wire [8:2] add_zero;
	for (genvar i = 2; i <= 8; i++) begin : g_zero
		assign add_zero[i] = shed_cfg[i][`SHED_ADD] == 8'h00 && 4'(i) <= top_n;
	end
	wire dps_off   = |add_zero; // RULE18
	wire boost_hit = OSC_PULSE && !boost_dis && n_act < top_n &&
		boost_prod <= {4'h0, period}; // RULE22 RULE23
	wire add_go  = CUR_VALID && add_ok && add_seen && n_act < top_n;
	wire drop_go = CUR_VALID && drop_ok && drop_seen &&
		drop_per >= drop_dly && n_act > floor_n;

	always_comb begin
		next_n_act = n_act;
		if (n_act < floor_n)
			next_n_act = floor_n;
		else if (dps_off || n_act > top_n)
			next_n_act = top_n;
		else if (boost_hit || add_go)
			next_n_act = n_act + 4'd1; // RULE15
		else if (drop_go)
			next_n_act = n_act - 4'd1; // RULE16
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			per_cnt <= 16'h0000;
		else
			per_cnt <= per_tick ? 16'h0000 : per_cnt + 16'h0001;
	end

	// one valid sample only starts the wait: a second one proves it lasted
	always_ff @(posedge CLK_SYS) begin
		if (!NRST || next_n_act != n_act) begin
			n_act     <= NRST ? next_n_act : `RST_ACTIVE;
			add_seen  <= 1'b0;
			drop_seen <= 1'b0;
			drop_per  <= 6'h00;
		end else begin
			if (CUR_VALID) begin
				add_seen  <= add_ok;
				drop_seen <= drop_ok;
			end
			if (CUR_VALID && !drop_ok)
				drop_per <= 6'h00;
			else if (drop_seen && per_tick && drop_per != 6'h3f)
				drop_per <= drop_per + 6'h01;
		end
	end

	assign PWM_OE        = active; // RULE16
	assign MON_EN        = active; // RULE15
	assign ACTIVE_PHASES = n_act;

	// ---------------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	sequence s_on_end;
		PWM_OUT[0] ##1 !PWM_OUT[0] && active[0];
	endsequence

	a_fixed_ton: assert property (!ff_en && ton_const == 10'h000 |-> // RULE3
		ton_nom == 16'h0003) else $error("fixed on time not three clocks");
	a_fll_idle: assert property (fll_gain == 10'h000 |=> // RULE5
		corr == 30'sh0) else $error("frequency loop not held off");
	a_lim_zero: assert property (lim_sel == LIM_ZERO |-> // RULE6
		corr_tot == 30'sh0) else $error("zero limit let correction through");
	a_min_off: assert property (s_on_end |=> !PWM_OUT[0] [*2]) // RULE13
		else $error("off time shorter than minimum");
	a_restart_on: assert property (pol == MERGE_RESTART && // RULE12
		g_ph[0].st == PH_ON && hit[0] |=> g_ph[0].cnt == $past(ton_ph[0]))
		else $error("on time not restarted");
	a_skip_on: assert property (pol[1] && g_ph[0].st == PH_ON && // RULE14
		hit[0] && g_ph[0].cnt > 16'h0001 |=>
		g_ph[0].cnt == $past(g_ph[0].cnt) - 16'h0001)
		else $error("pulse during on time not skipped");
	a_drop_wait: assert property (next_n_act < n_act && // RULE16
		n_act <= top_n |-> drop_per >= drop_dly && drop_seen)
		else $error("phase dropped before delay");
	a_add_wait: assert property (next_n_act > n_act && // RULE15
		n_act >= floor_n && !dps_off && !boost_hit |-> add_seen && CUR_VALID)
		else $error("phase added before latency");
	a_floor_min: assert property (##1 n_act >= $past(floor_n)) // RULE20
		else $error("active phases below minimum");
	a_boost_step: assert property (boost_hit && !dps_off && // RULE22
		n_act >= floor_n |=> n_act == $past(n_act) + 4'd1)
		else $error("boost did not add a phase");
endmodule : pwm_modulator
`default_nettype wire

/* bench/power_stage_model.sv */
// power stage and current sense model feeding the modulator's loop inputs
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// phase drivers
	input  wire logic [7:0]  pwm_oe,
	// load set by the bench
	input  wire logic [15:0] load,
	input  wire logic [7:0]  ph_level,
	input  wire logic [7:0]  avg_level,
	// sensed currents
	output logic      [63:0] phase_current,
	output logic      [7:0]  avg_current,
	output logic      [15:0] sum_current,
	output logic             cur_valid
);
	logic [3:0] tick = 4'h0;
	// --------
	// free running converter, a sample every 16 clocks
	// --------
	always @(posedge clk) begin
		tick <= nrst ? tick + 4'h1 : 4'h0;
		cur_valid <= nrst && tick == 4'hf;
		sum_current <= load;
		avg_current <= avg_level;
		// a tristated phase carries no current
		for (int k = 0; k < 8; k++)
			phase_current[8*k +: 8] <= pwm_oe[k] ? ph_level : 8'h00;
	end
endmodule : power_stage_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench of the pwm modulator core
`timescale 1ns/1ns
`default_nettype none
`include "pwm_mod_cfg.svh"
module tb import pwm_mod_pkg::*;;
	// --------
	// signals
	// --------
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        osc = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rnd = 32'h0000_002e;
	logic [15:0] osc_per = 16'hffff;
	logic [15:0] load = 16'h0000;
	logic [11:0] vin = 12'h800;
	logic [11:0] vout = 12'h100;
	logic [7:0]  ph = 8'h14;
	logic [7:0]  pwm, oe, mon, acur;
	logic [63:0] pcur;
	logic [15:0] scur;
	logic [31:0] prdata, ctl, rd, v;
	logic [3:0]  act;
	logic        pready, pslverr, serr, cval;
	int          fails = 0;
	int          n_tests = 0;
	int          hi_cnt = 0;
	localparam logic [31:0] RV [12] = '{`RST_CTRL, `RST_TON, `RST_PERIOD,
		`RST_BAL, `RST_SPREAD, {16'h0, `RST_SHED2}, {16'h0, `RST_SHED3},
		{16'h0, `RST_SHED4}, {16'h0, `RST_SHED5}, {16'h0, `RST_SHED6},
		{16'h0, `RST_SHED7}, {16'h0, `RST_SHED8}};

	always #10 clk = ~clk;
	// total on cycles of all phases, differenced around each shot
	always @(posedge clk) hi_cnt <= hi_cnt + $countones(pwm);

	pwm_modulator pwm_modulator_i (
		.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .OSC_PULSE(osc),
		.OSC_PERIOD(osc_per), .VIN_CODE(vin), .VOUT_CODE(vout),
		.PHASE_CURRENT(pcur), .AVG_CURRENT(acur), .SUM_CURRENT(scur),
		.CUR_VALID(cval), .PWM_OUT(pwm), .PWM_OE(oe), .MON_EN(mon),
		.ACTIVE_PHASES(act));
	power_stage_model power_stage_model_i (
		.clk(clk), .nrst(nrst), .pwm_oe(oe), .load(load), .ph_level(ph),
		.avg_level(8'h14), .phase_current(pcur), .avg_current(acur),
		.sum_current(scur), .cur_valid(cval));

	// --------
	// helpers
	// --------
	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction : xs
	function automatic int exp_w(input int pol, input int gap, input int t);
		if (gap > t + 3)
			return 2 * t;
		if (gap > t)
			return pol == 3 ? t : 2 * t;
		return pol == 0 ? 2 * t : pol == 1 ? gap + t : t;
	endfunction : exp_w
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wv();
		do @(posedge clk); while (cval !== 1'b1);
	endtask : wv
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_act(input logic [3:0] n, input int lim);
		for (int k = 0; k < lim && act !== n; k++)
			@(posedge clk);
		chk("active", {28'h0, n}, {28'h0, act});
		chk("oe", (32'h1 << n) - 32'h1, {24'h0, oe});
		chk("mon", (32'h1 << n) - 32'h1, {24'h0, mon});
	endtask : wait_act
	// two oscillator pulses gap cycles apart, returns on cycles seen
	task automatic shots(input int gap, output int w);
		int h0;
		h0 = hi_cnt;
		@(posedge clk);
		osc <= 1'b1;
		@(posedge clk);
		osc <= 1'b0;
		repeat (gap - 1) @(posedge clk);
		osc <= 1'b1;
		@(posedge clk);
		osc <= 1'b0;
		cyc(80);
		w = hi_cnt - h0;
	endtask : shots
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	initial begin
		#(20 * 40000);
		fails++;
		stop_test();
	end

	// --------
	// scenarios
	// --------
	initial begin
		int w, c, i, t;
		logic [3:0] n;
		cyc(20);
		nrst <= 1'b1;
		cyc(1);
		wait_act(4'h8, 1);
		chk("pwm idle", 32'h0, {24'h0, pwm});
		for (i = 0; i < 12; i++) begin
			apb(1'b0, 8'(i < 5 ? 4 * i : 12 + 4 * i), 32'h0);
			chk("reset", RV[i], rd);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, serr});
		chk("unmapped data", 32'h0, rd);
		v = xs() & 32'h7fff_ffff;
		apb(1'b1, `OFF_SPREAD, v);
		apb(1'b0, `OFF_SPREAD, 32'h0);
		chk("spread", v, rd);
		done("registers");
		ctl = `RST_CTRL;
		ctl[`CTRL_BOOST_DIS] = 1'b1;
		ctl[`CTRL_ASSIGNED] = 4'h1;
		apb(1'b1, `OFF_CTRL, ctl);
		apb(1'b1, `OFF_PERIOD, 32'h14);
		wait_act(4'h1, 3000);
		for (i = 0; i < 4; i++) begin
			c = i == 0 ? 0 : i == 1 ? 1023 : xs() & 32'h3ff;
			apb(1'b1, `OFF_TON, c);
			cyc(3);
			apb(1'b0, `OFF_STATUS, 32'h0);
			chk("fixed on time", 3 + c, rd >> 16);
		end
		apb(1'b1, `OFF_TON, 32'h7);
		for (i = 0; i < 12; i++) begin
			ctl[`CTRL_MERGE] = 2'(i / 3);
			apb(1'b1, `OFF_CTRL, ctl);
			t = i % 3 == 0 ? 4 : i % 3 == 1 ? 11 : 40;
			shots(t, w);
			chk("merged", exp_w(i / 3, t, 10), w);
		end
		done("merge");
		ph <= 8'h0e;
		cyc(40);
		for (i = 0; i < 3; i++) begin
			c = xs() & 32'hff;
			apb(1'b1, `OFF_BAL, c);
			shots(40, w);
			chk("balanced", 2 * (10 + (6 * c >>> 6)), w);
		end
		ph <= 8'h14;
		done("balance");
		ctl[`CTRL_FF_EN] = 1'b1;
		apb(1'b1, `OFF_CTRL, ctl);
		for (i = 0; i < 4; i++) begin
			c = (xs() & 32'hffff) | 32'h1;
			vout <= 12'(xs()) & 12'h7ff;
			vin <= 12'(xs()) | 12'h800;
			apb(1'b1, `OFF_PERIOD, c);
			cyc(3);
			apb(1'b0, `OFF_STATUS, 32'h0);
			chk("feedforward", vout * c / vin, rd >> 16);
		end
		ctl[`CTRL_FF_EN] = 1'b0;
		apb(1'b1, `OFF_CTRL, ctl);
		apb(1'b1, `OFF_PERIOD, 32'h14);
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk("fixed on time", 32'd10, rd >> 16);
		done("feedforward");
		// period far below target so the loop has an error to act on
		osc_per <= 16'h0005;
		apb(1'b1, `OFF_TON, 32'h03ff_0007);
		ctl[`CTRL_LIMIT] = LIM_ZERO;
		apb(1'b1, `OFF_CTRL, ctl);
		shots(40, w);
		shots(40, w);
		chk("zero limit", 32'd20, w);
		ctl[`CTRL_LIMIT] = LIM_FULL;
		apb(1'b1, `OFF_CTRL, ctl);
		for (i = 0; i < 3; i++)
			shots(40, w);
		chk("loop trims", 32'h1, {31'h0, w != 20 && w <= 40});
		apb(1'b1, `OFF_TON, 32'h7);
		shots(40, w);
		chk("loop off", 32'd20, w);
		done("fll");
		// error-free period, so only the spread ramp moves the on time
		osc_per <= 16'h0014;
		apb(1'b1, `OFF_TON, 32'h0001_0007);
		apb(1'b1, `OFF_SPREAD, 32'h0200_0200);
		ctl[`CTRL_SS_EN] = 1'b1;
		apb(1'b1, `OFF_CTRL, ctl);
		c = 512 * `SSM_LSB_NS / 128 / `CLK_PERIOD_NS;
		shots(40, w);
		chk("spread up", 20 + c, w);
		shots(40, w);
		chk("spread down", 20 - c, w);
		ctl[`CTRL_SS_EN] = 1'b0;
		apb(1'b1, `OFF_CTRL, ctl);
		shots(40, w);
		chk("spread off", 32'd20, w);
		apb(1'b1, `OFF_TON, 32'h7);
		done("spread");
		ctl[`CTRL_ASSIGNED] = 4'h8;
		ctl[`CTRL_SHED_DLY] = 2'h1;
		load <= 16'h000d;
		apb(1'b1, `OFF_CTRL, ctl);
		osc_per <= 16'h000a;
		shots(40, w);
		wait_act(4'h1, 1);
		ctl[`CTRL_BOOST_DIS] = 1'b0;
		apb(1'b1, `OFF_CTRL, ctl);
		shots(40, w);
		wait_act(4'h2, 1);
		osc_per <= 16'hffff;
		load <= 16'h0000;
		cyc(250);
		wait_act(4'h2, 1);
		wait_act(4'h1, 200);
		load <= 16'h000f;
		cyc(1);
		wv();
		cyc(3);
		wait_act(4'h1, 1);
		wv();
		cyc(2);
		wait_act(4'h2, 1);
		done("boost");
		ctl[`CTRL_ASSIGNED] = 4'h2;
		load <= 16'h0000;
		for (i = 0; i < 3; i++) begin
			ctl[`CTRL_MIN_PH] = i == 0 ? 3'h4 : i == 1 ? 3'h7 : 3'h0;
			n = i == 0 ? 4'h4 : i == 1 ? 4'h7 : 4'h1;
			apb(1'b1, `OFF_CTRL, ctl);
			wait_act(n, 3000);
			cyc(500);
			wait_act(n, 1);
		end
		ctl[`CTRL_ASSIGNED] = 4'h5;
		apb(1'b1, `OFF_CTRL, ctl);
		apb(1'b1, `OFF_SHED_BASE, 32'h0000_0b00);
		wait_act(4'h5, 50);
		cyc(500);
		wait_act(4'h5, 1);
		done("shedding");
		stop_test();
	end
endmodule : tb
`default_nettype wire
